// ===== hdl/acc_ctrl.sv
`timescale 1ns/1ns
`include "acc_cfg.svh"
module acc_ctrl
  import acc_pkg::*;
#(
  parameter int TICK_CYC = `ACC_TICK_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Analog converter core
  input wire logic i_cmp,
  output logic [9:0] o_dac_code,
  output logic o_sample,
  output logic o_bias_en,
  output logic [2:0] o_chan_sel,
  // Interrupt and PWM mask outputs
  output logic o_conv_irq,
  output logic o_pwm_a_irq_en,
  output logic o_pwm_b_irq_en
);
  acc_conv_if cif ();

  logic [7:0] ctrl;
  logic [7:0] mask;
  logic flag;
  logic [7:0] res_lo;
  logic [1:0] res_hi;
  logic cmp_s1;
  logic cmp_s2;

  logic setup;
  logic access;
  logic wr;
  logic sel_ctrl;
  logic sel_mask;
  logic sel_flag;
  logic sel_lo;
  logic sel_hi;
  logic mapped;
  logic wr_ctrl;
  logic wr_mask;
  logic wr_flag;
  logic done_masked;
  logic next_start;
  logic next_flag;
  logic [7:0] rd_val;

  // Bus decode
  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable && o_pready;
  assign wr = access && i_pwrite;
  assign sel_ctrl = acc_hit(i_paddr, `ACC_OFF_CTRL);
  assign sel_mask = acc_hit(i_paddr, `ACC_OFF_MASK);
  assign sel_flag = acc_hit(i_paddr, `ACC_OFF_FLAG);
  assign sel_lo = acc_hit(i_paddr, `ACC_OFF_RES_LO);
  assign sel_hi = acc_hit(i_paddr, `ACC_OFF_RES_HI);
  assign mapped = sel_ctrl || sel_mask || sel_flag || sel_lo || sel_hi;
  assign wr_ctrl = wr && sel_ctrl;
  assign wr_mask = wr && sel_mask;
  assign wr_flag = wr && sel_flag;

  // Conversion end only counts as an event while the mask is set
  assign done_masked = cif.done && mask[`ACC_MASK_DONE];

  // A write of one wins over the hardware clear in the same cycle
  assign next_start = (wr_ctrl && i_pwdata[`ACC_CTRL_START]) ||
                      (!wr_ctrl && ctrl[`ACC_CTRL_START] &&
                       !done_masked);

  // Writing zero to the flag clears it; a new event wins
  assign next_flag = done_masked ||
                     (flag && !(wr_flag &&
                                !i_pwdata[`ACC_FLAG_DONE]));

  always_comb begin
    rd_val = 8'h00;
    if (sel_ctrl) begin
      rd_val = ctrl;
    end else if (sel_mask) begin
      rd_val = mask;
    end else if (sel_flag) begin
      rd_val[`ACC_FLAG_DONE] = flag;
    end else if (sel_lo) begin
      rd_val = res_lo;
    end else if (sel_hi) begin
      rd_val[`ACC_RES_HI_LSB +: 2] = res_hi;
    end
  end

  // Converter only runs with bias on
  assign cif.go = ctrl[`ACC_CTRL_START] && ctrl[`ACC_CTRL_POWER];
  assign cif.rate_sel = ctrl[`ACC_CTRL_RATE_LSB +: 2];
  assign cif.cmp = cmp_s2;

  acc_conv_seq #(
    .TICK_CYC(TICK_CYC)
  ) u_seq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .cif(cif)
  );

  // Comparator comes from the analog core, outside the clock domain
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
    end else begin
      cmp_s1 <= i_cmp;
      cmp_s2 <= cmp_s1;
    end
  end

  // APB: no wait state; ready and read data are loaded from flops in the setup cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup && !mapped;
      if (setup) begin
        o_prdata <= {24'h00_0000, rd_val};
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl <= `ACC_CTRL_RST;
      mask <= `ACC_MASK_RST;
      flag <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= i_pwdata[7:0] & `ACC_CTRL_WMASK;
      end
      ctrl[`ACC_CTRL_START] <= next_start;
      if (wr_mask) begin
        // Unused bit 6 is not stored
        mask <= i_pwdata[7:0] & `ACC_MASK_WMASK;
      end
      flag <= next_flag;
    end
  end

  // Both halves load in one edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      res_lo <= 8'h00;
      res_hi <= 2'b00;
    end else if (cif.done) begin
      res_lo <= cif.result[7:0];
      res_hi <= cif.result[9:8];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bias_en <= 1'b0;
      o_chan_sel <= 3'b000;
      o_conv_irq <= 1'b0;
      o_pwm_a_irq_en <= 1'b0;
      o_pwm_b_irq_en <= 1'b0;
    end else begin
      o_bias_en <= ctrl[`ACC_CTRL_POWER];
      o_chan_sel <= ctrl[`ACC_CTRL_CHAN_LSB +: 3];
      o_conv_irq <= flag && mask[`ACC_MASK_DONE];
      o_pwm_a_irq_en <= mask[`ACC_MASK_PWM_A];
      o_pwm_b_irq_en <= mask[`ACC_MASK_PWM_B];
    end
  end

  assign o_dac_code = cif.dac_code;
  assign o_sample = cif.sample;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_end_masked;
    cif.done && mask[`ACC_MASK_DONE] &&
      !(wr_ctrl && i_pwdata[`ACC_CTRL_START]);
  endsequence

  sequence s_end_free;
    cif.done && !mask[`ACC_MASK_DONE] && ctrl[`ACC_CTRL_START] &&
      !wr_ctrl && !wr_flag;
  endsequence

  property p_start_go;
    wr_ctrl && i_pwdata[`ACC_CTRL_START] &&
      i_pwdata[`ACC_CTRL_POWER] |=> cif.go;
  endproperty
  a_start_go: assert property (p_start_go)
    else $error("start write did not enable conversion");

  property p_auto_clear;
    s_end_masked |=> !ctrl[`ACC_CTRL_START] ##1 !cif.busy;
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("start bit not cleared at masked conversion end");

  property p_flag_set;
    cif.done && mask[`ACC_MASK_DONE] && !wr_mask |=> flag ##1 o_conv_irq;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("completion flag or interrupt missing");

  property p_flag_hold;
    flag && !wr_flag |=> flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("completion flag dropped without software");

  property p_free_run;
    s_end_free |=> ctrl[`ACC_CTRL_START] && flag == $past(flag);
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("free run changed start bit or flag");

  property p_result_pair;
    cif.done |=> {res_hi, res_lo} == $past(cif.result);
  endproperty
  a_result_pair: assert property (p_result_pair)
    else $error("result registers not loaded together");

  property p_power_off;
    !ctrl[`ACC_CTRL_POWER] |=> !cif.busy && !o_bias_en;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("converter active with power bit clear");

  property p_irq_gate;
    !mask[`ACC_MASK_DONE] && !wr_mask |=> !o_conv_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised with mask clear");

  property p_pwm_masks;
    wr_mask |=> ##1 o_pwm_a_irq_en == $past(i_pwdata[4], 2) &&
      o_pwm_b_irq_en == $past(i_pwdata[7], 2);
  endproperty
  a_pwm_masks: assert property (p_pwm_masks)
    else $error("PWM mask outputs do not follow the mask write");

  property p_chan_route;
    wr_ctrl |=> ##1 o_chan_sel == $past(i_pwdata[7:5], 2);
  endproperty
  a_chan_route: assert property (p_chan_route)
    else $error("channel select output wrong");

  sequence s_setup;
    i_psel && !i_penable;
  endsequence

  sequence s_clear_flag;
    wr_flag && !i_pwdata[`ACC_FLAG_DONE];
  endsequence

  property p_ready_next;
    s_setup |=> o_pready;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("no ready in the access cycle");

  property p_err_unmapped;
    s_setup && !mapped |=> o_pslverr && o_prdata == 32'h0000_0000;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped access without error or with data");

  property p_read_ctrl;
    s_setup && sel_ctrl |=> o_prdata[7:0] == $past(ctrl);
  endproperty
  a_read_ctrl: assert property (p_read_ctrl)
    else $error("control read data wrong");

  // A masked conversion end in the same cycle keeps the flag set
  property p_flag_clear;
    s_clear_flag && !done_masked |=> !flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag not cleared by software");

  property p_flag_no_sw_set;
    wr_flag && i_pwdata[`ACC_FLAG_DONE] && !flag && !done_masked |=>
      !flag;
  endproperty
  a_flag_no_sw_set: assert property (p_flag_no_sw_set)
    else $error("software write set the completion flag");

  property p_start_hold;
    ctrl[`ACC_CTRL_START] && !mask[`ACC_MASK_DONE] && !wr_ctrl |=>
      ctrl[`ACC_CTRL_START];
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start bit dropped while free running");

  property p_start_clear;
    wr_ctrl && !i_pwdata[`ACC_CTRL_START] |=> !ctrl[`ACC_CTRL_START];
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("start bit kept after a zero write");

  property p_bias_on;
    ctrl[`ACC_CTRL_POWER] |=> o_bias_en;
  endproperty
  a_bias_on: assert property (p_bias_on)
    else $error("bias off with power bit set");

  property p_abort;
    cif.busy && !cif.go |=> !cif.busy && !cif.sample;
  endproperty
  a_abort: assert property (p_abort)
    else $error("conversion kept running without start or power");

  property p_result_hold;
    !cif.done |=> $stable(res_lo) && $stable(res_hi);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed outside a conversion end");

  property p_irq_follow;
    flag && mask[`ACC_MASK_DONE] |=> o_conv_irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("interrupt missing with flag and mask set");

  property p_mask_store;
    wr_mask |=> mask[`ACC_MASK_DONE] == $past(i_pwdata[`ACC_MASK_DONE]) &&
      !mask[6];
  endproperty
  a_mask_store: assert property (p_mask_store)
    else $error("completion mask not stored as written");

  property p_rate_follow;
    wr_ctrl |=> cif.rate_sel == $past(i_pwdata[`ACC_CTRL_RATE_LSB +: 2]);
  endproperty
  a_rate_follow: assert property (p_rate_follow)
    else $error("rate select does not follow the control write");
endmodule

// ===== include/acc_cfg.svh
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

`define ACC_CLK_HZ 20000000
`define ACC_RATE_HZ 74600
`define ACC_CONV_TICKS 12
`define ACC_TICK_CYC ((`ACC_CLK_HZ) / ((`ACC_RATE_HZ) * (`ACC_CONV_TICKS)))
`define ACC_MIN_CONV_NS 13000

`define ACC_OFF_CTRL 8'h00
`define ACC_OFF_MASK 8'h04
`define ACC_OFF_FLAG 8'h08
`define ACC_OFF_RES_LO 8'h0C
`define ACC_OFF_RES_HI 8'h10

`define ACC_CTRL_START 0
`define ACC_CTRL_POWER 2
`define ACC_CTRL_RATE_LSB 3
`define ACC_CTRL_CHAN_LSB 5
`define ACC_CTRL_WMASK 8'hFD
`define ACC_CTRL_RST 8'h00

`define ACC_MASK_PWM_A 4
`define ACC_MASK_DONE 5
`define ACC_MASK_PWM_B 7
`define ACC_MASK_WMASK 8'hB0
`define ACC_MASK_RST 8'h00

`define ACC_FLAG_DONE 5
`define ACC_RES_HI_LSB 4

`endif

// ===== include/acc_pkg.sv
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_SAMPLE,
    ACC_TRIAL,
    ACC_FINISH
  } acc_state_t;

  typedef logic [9:0] acc_result_t;

  function automatic logic acc_hit(input logic [7:0] addr,
                                   input logic [7:0] off);
    acc_hit = (addr == off);
  endfunction
endpackage

// ===== include/acc_conv_if.sv
`timescale 1ns/1ns
interface acc_conv_if;
  import acc_pkg::*;
  logic go;
  logic [1:0] rate_sel;
  logic cmp;
  logic done;
  logic busy;
  logic sample;
  acc_result_t dac_code;
  acc_result_t result;

  modport ctl (
    output go, rate_sel, cmp,
    input done, busy, sample, dac_code, result
  );
  modport seq (
    input go, rate_sel, cmp,
    output done, busy, sample, dac_code, result
  );
endinterface

// ===== hdl/acc_conv_seq.sv
`timescale 1ns/1ns
`include "acc_cfg.svh"
module acc_conv_seq
  import acc_pkg::*;
#(
  parameter int TICK_CYC = `ACC_TICK_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Controller side
  acc_conv_if.seq cif
);
  localparam logic [7:0] BASE = 8'(TICK_CYC - 1);

  acc_state_t state;
  logic [7:0] div_cnt;
  logic [3:0] bit_idx;
  logic [3:0] tick_cnt;
  logic [7:0] reload;
  logic tick;

  // Slower rates double the period per step
  assign reload = 8'(((TICK_CYC) << cif.rate_sel) - 1);
  assign tick = (div_cnt == 8'h00);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt <= BASE;
    end else if (tick || (state == ACC_IDLE && !cif.go)) begin
      div_cnt <= reload;
    end else begin
      div_cnt <= div_cnt - 8'h01;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ACC_IDLE;
      bit_idx <= 4'h0;
      cif.dac_code <= 10'h000;
      cif.sample <= 1'b0;
      cif.done <= 1'b0;
      cif.result <= 10'h000;
    end else begin
      cif.done <= 1'b0;
      if (!cif.go) begin
        // Dropping start or power aborts without a result
        state <= ACC_IDLE;
        cif.sample <= 1'b0;
      end else if (tick) begin
        unique case (state)
          ACC_IDLE: begin
            state <= ACC_SAMPLE;
            cif.sample <= 1'b1;
          end
          ACC_SAMPLE: begin
            state <= ACC_TRIAL;
            cif.sample <= 1'b0;
            bit_idx <= 4'd9;
            cif.dac_code <= 10'h200;
          end
          ACC_TRIAL: begin
            cif.dac_code[bit_idx] <= cif.cmp;
            if (bit_idx == 4'd0) begin
              state <= ACC_FINISH;
            end else begin
              cif.dac_code[bit_idx - 4'd1] <= 1'b1;
              bit_idx <= bit_idx - 4'd1;
            end
          end
          ACC_FINISH: begin
            state <= ACC_IDLE;
            cif.done <= 1'b1;
            cif.result <= cif.dac_code;
          end
        endcase
      end
    end
  end

  assign cif.busy = (state != ACC_IDLE);

  // Helper for checking the conversion length
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt <= 4'h0;
    end else if (tick) begin
      tick_cnt <= (state == ACC_IDLE) ? 4'h0 : tick_cnt + 4'h1;
    end
  end

  property p_conv_len;
    @(posedge i_clk) disable iff (i_rst)
    (tick && cif.go && state == ACC_FINISH) |->
      (tick_cnt == 4'd11) ##1 cif.done;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion did not take twelve periods");
endmodule

// ===== bench/acc_core_model.sv
`timescale 1ns/1ns
module acc_core_model (
  // Clock
  input wire logic i_clk,
  // From controller
  input wire logic [9:0] i_dac_code,
  input wire logic i_sample,
  input wire logic i_bias_en,
  input wire logic [2:0] i_chan_sel,
  // To controller
  output logic o_cmp
);
  logic [9:0] level [8];
  logic [9:0] held;

  initial begin
    for (int k = 0; k < 8; k++) begin
      level[k] = 10'h3A5 - 10'(k * 10'h075);
    end
    held = 10'h000;
    o_cmp = 1'b0;
  end

  always @(posedge i_clk) begin
    if (i_sample) begin
      held <= level[i_chan_sel];
    end
  end

  // Unpowered core gives no stable answer, so toggle
  always @(posedge i_clk) begin
    if (i_bias_en) begin
      o_cmp <= (held >= i_dac_code);
    end else begin
      o_cmp <= ~o_cmp;
    end
  end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ns
`include "acc_cfg.svh"
module testbench;
  import acc_pkg::*;
  // Room for the core's comparator flop and the two-stage synchroniser
  localparam int TICK = 4;
  logic i_clk, i_rst, i_psel, i_penable, i_pwrite, i_cmp;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic o_pready, o_pslverr, o_sample, o_bias_en, err;
  logic o_conv_irq, o_pwm_a_irq_en, o_pwm_b_irq_en;
  logic [9:0] o_dac_code, v;
  logic [2:0] o_chan_sel;
  int error_cnt, checks;

  acc_ctrl #(.TICK_CYC(TICK)) dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_cmp(i_cmp),
    .o_dac_code(o_dac_code), .o_sample(o_sample),
    .o_bias_en(o_bias_en), .o_chan_sel(o_chan_sel),
    .o_conv_irq(o_conv_irq), .o_pwm_a_irq_en(o_pwm_a_irq_en),
    .o_pwm_b_irq_en(o_pwm_b_irq_en));

  acc_core_model core (.i_clk(i_clk), .i_dac_code(o_dac_code),
    .i_sample(o_sample), .i_bias_en(o_bias_en),
    .i_chan_sel(o_chan_sel), .o_cmp(i_cmp));

  always #25 i_clk = ~i_clk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task complete_run;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Entered just after a rising edge; leaves just after one
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      complete_run();
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk(err, 1'b0);
  endtask

  task poll_done;
    int n;
    n = 0;
    do begin
      xfer(1'b0, `ACC_OFF_FLAG, 32'h0000_0000);
      n++;
    end while (rd[5] !== 1'b1 && n < 200);
    if (n >= 200) begin
      error_cnt++;
      complete_run();
    end
  endtask

  task samp_width(input int exp);
    int n, w;
    n = 0;
    w = 0;
    while (o_sample !== 1'b1 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    while (o_sample === 1'b1 && w < 400) begin
      @(posedge i_clk);
      w++;
    end
    chk(w, exp);
  endtask

  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0000_0000;
    error_cnt = 0;
    checks = 0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rdc(`ACC_OFF_CTRL, 32'h0000_0000);
    rdc(`ACC_OFF_MASK, 32'h0000_0000);
    rdc(`ACC_OFF_FLAG, 32'h0000_0000);
    xfer(1'b1, `ACC_OFF_MASK, 32'h0000_00B0);
    rdc(`ACC_OFF_MASK, 32'h0000_00B0);
    chk({o_pwm_b_irq_en, o_pwm_a_irq_en}, 2'b11);
    xfer(1'b1, `ACC_OFF_MASK, 32'h0000_0020);
    // Mask outputs follow the stored mask one edge later
    @(posedge i_clk);
    chk({o_pwm_b_irq_en, o_pwm_a_irq_en}, 2'b00);
    xfer(1'b0, 8'h14, 32'h0000_0000);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    // Every channel once, rate cycling through all four steps
    for (int c = 0; c < 8; c++) begin
      v = 10'h3A5 - 10'(c * 10'h075);
      xfer(1'b1, `ACC_OFF_CTRL, {24'h0, 3'(c), 2'(c), 3'b100});
      xfer(1'b1, `ACC_OFF_CTRL, {24'h0, 3'(c), 2'(c), 3'b101});
      samp_width(TICK << (c % 4));
      chk({o_bias_en, o_chan_sel}, {1'b1, 3'(c)});
      poll_done();
      chk(o_conv_irq, 1'b1);
      rdc(`ACC_OFF_CTRL, {24'h0, 3'(c), 2'(c), 3'b100});
      rdc(`ACC_OFF_RES_LO, {24'h0, v[7:0]});
      rdc(`ACC_OFF_RES_HI, {26'h0, v[9:8], 4'h0});
      rdc(`ACC_OFF_FLAG, 32'h0000_0020);
      xfer(1'b1, `ACC_OFF_FLAG, 32'h0000_0000);
      rdc(`ACC_OFF_FLAG, 32'h0000_0000);
      chk(o_conv_irq, 1'b0);
    end
    // Mask clear: free running, three sample phases in a row
    xfer(1'b1, `ACC_OFF_MASK, 32'h0000_0000);
    xfer(1'b1, `ACC_OFF_CTRL, 32'h0000_0004);
    xfer(1'b1, `ACC_OFF_CTRL, 32'h0000_0005);
    repeat (3) samp_width(TICK);
    rdc(`ACC_OFF_CTRL, 32'h0000_0005);
    rdc(`ACC_OFF_FLAG, 32'h0000_0000);
    chk(o_conv_irq, 1'b0);
    xfer(1'b1, `ACC_OFF_MASK, 32'h0000_0020);
    poll_done();
    rdc(`ACC_OFF_CTRL, 32'h0000_0004);
    xfer(1'b1, `ACC_OFF_FLAG, 32'h0000_0000);
    // Start without power must not convert
    xfer(1'b1, `ACC_OFF_CTRL, 32'h0000_0001);
    @(posedge i_clk);
    chk(o_bias_en, 1'b0);
    repeat (60) @(posedge i_clk);
    chk(o_sample, 1'b0);
    rdc(`ACC_OFF_FLAG, 32'h0000_0000);
    complete_run();
  end
endmodule
